// ---- cvr_assertions.sv ----
// checker on the ports of the control block
// assumes a bind into cvr_control, one clock domain
`timescale 1ns/100ps
`default_nettype none
module cvr_assertions (
    input wire logic       ref_clk,
    input wire logic       reset,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic       wb_err_o,
    input wire logic       comparator_result,
    input wire logic [2:0] comparator_mode_field,
    input wire logic       input_switch,
    input wire logic       switch_active,
    input wire logic       timer_clk_prescaled,
    input wire logic       timer_on,
    input wire logic       timer_gate_enable,
    input wire logic       external_gate_pin,
    input wire logic       timer_gate,
    input wire logic       timer_count_en,
    input wire logic       reference_enable,
    input wire logic       reference_range_select,
    input wire logic [3:0] reference_level,
    input wire logic       ladder_power,
    input wire logic [7:0] reference_output
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    chk_switch_route: assert property (
        switch_active == (input_switch && (comparator_mode_field == 3'h6
        || comparator_mode_field == 3'h5))) else $error("switch route");
    chk_gate_source: assert property (
        timer_gate == external_gate_pin || timer_gate == comparator_result)
        else $error("gate source");
    chk_count_run: assert property (
        timer_count_en |-> timer_on && !$past(timer_count_en)
        && (!timer_gate_enable || timer_gate))
        else $error("count while off");
    chk_count_rise: assert property (
        timer_count_en |-> timer_clk_prescaled
        && !$past(timer_clk_prescaled)) else $error("count edge");
    chk_ref_off: assert property (
        !reference_enable |=> reference_output == 8'h00 && !ladder_power)
        else $error("reference not off");
    chk_ladder_on: assert property (
        reference_enable |=> ladder_power) else $error("ladder off");
    chk_ref_low: assert property (
        reference_enable && reference_range_select |=>
        reference_output == {2'h0, $past(reference_level), 2'h0})
        else $error("low range");
    chk_ref_high: assert property (
        reference_enable && !reference_range_select |=>
        reference_output == 8'h18 + 8'h03 * $past(reference_level))
        else $error("high range");
    chk_bus_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
        |=> wb_ack_o || wb_err_o)
        else $error("no answer");
endmodule // cvr_assertions
bind cvr_control cvr_assertions u_chk (.ref_clk, .reset, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .wb_err_o, .comparator_result,
    .comparator_mode_field, .input_switch, .switch_active,
    .timer_clk_prescaled, .timer_on, .timer_gate_enable,
    .external_gate_pin, .timer_gate,
    .timer_count_en, .reference_enable, .reference_range_select,
    .reference_level, .ladder_power, .reference_output);
`default_nettype wire

// ---- cvr_consts.vh ----
// constants for the comparator and reference control block
// assumes inclusion by bare name from the design file
`ifndef CVR_CONSTS_VH
`define CVR_CONSTS_VH

// word byte offsets on the wishbone bus
`define CVR_ADR_CMP_CFG      4'h0
`define CVR_ADR_GATE_SYNC    4'h4
`define CVR_ADR_VREF_CTRL    4'h8
`define CVR_ADR_STATUS       4'hC

// comparator configuration fields
`define CVR_BIT_RESULT       6
`define CVR_BIT_INVERT       4
`define CVR_BIT_SWITCH       3
`define CVR_MODE_HI          2
`define CVR_MODE_LO          0
`define CVR_MODE_SW_A        3'h6
`define CVR_MODE_SW_B        3'h5

// gate and sync fields
`define CVR_BIT_GATE_SEL     1
`define CVR_BIT_SYNC_EN      0

// reference control fields
`define CVR_BIT_REF_EN       7
`define CVR_BIT_REF_RANGE    5
`define CVR_LEVEL_HI         3
`define CVR_LEVEL_LO         0

// reset values
`define CVR_RST_CMP_CFG      8'h00
`define CVR_RST_GATE_SYNC    8'h02
`define CVR_RST_VREF_CTRL    8'h00

// writable bit masks
`define CVR_MSK_CMP_CFG      8'h1F
`define CVR_MSK_GATE_SYNC    8'h03
`define CVR_MSK_VREF_CTRL    8'hAF

// reference ladder arithmetic, in units of supply over 96
`define CVR_LOW_STEP         8'h04
`define CVR_HIGH_BASE        8'h18
`define CVR_HIGH_STEP        8'h03

`endif

// ---- cvr_control.v ----
// comparator output conditioning, timer gate select and reference control
// assumes a classic wishbone master on ref_clk; timer clock is a
// synchronous level input, prescaled by the timer when that is in use
//
// How it works
// - invert bit flips comparator result
// - switch bit routes inputs in modes 110/101
// - comparator gates timer when select cleared
// - select bit: 1 gate pin, 0 comparator
// - sync bit latches on timer clock fall
// - latch uses prescaled timer clock
// - timer counts on rising clock edge
// - enable bit powers reference regardless of mode
// - disabled reference: ladder off, output grounded
// - range bit: 1 low, 0 high
// - four-bit level picks sixteen steps
// - low range: level over 24 of supply
// - high range: quarter plus level over 32
// - upper six gate bits read zero
`timescale 1ns/100ps
`default_nettype none
`include "cvr_consts.vh"

module cvr_control #(
    parameter DATA_W = 32
) (
    input  wire              ref_clk,
    input  wire              reset,
    // wishbone slave
    input  wire              wb_cyc_i,
    input  wire              wb_stb_i,
    input  wire              wb_we_i,
    input  wire [3:0]        wb_adr_i,
    input  wire [3:0]        wb_sel_i,
    input  wire [DATA_W-1:0] wb_dat_i,
    output reg  [DATA_W-1:0] wb_dat_o,
    output wire              wb_ack_o,
    output wire              wb_err_o,
    // analog comparator side
    input  wire              comparator_raw,
    output reg               comparator_result,
    output wire [2:0]        comparator_mode_field,
    output wire              input_switch,
    output wire              switch_active,
    // timer side
    input  wire              timer_clk_prescaled,
    input  wire              timer_on,
    input  wire              timer_gate_enable,
    input  wire              external_gate_pin,
    output reg               timer_gate,
    output reg               timer_count_en,
    // reference ladder side
    output wire              reference_enable,
    output wire              reference_range_select,
    output wire [3:0]        reference_level,
    output reg               ladder_power,
    output reg  [7:0]        reference_output
);

// ---------------------------------------------------------------------
// registers
// ---------------------------------------------------------------------
reg  [7:0] cmp_cfg_ff;
reg  [7:0] comparator_gate_sync_config_ff;
reg  [7:0] voltage_reference_control_ff;
reg        ack_ff;
reg        tclk_prev_ff;
reg        sync_out_ff;
reg  [7:0] nxt_rdata;
reg        nxt_hit;

wire req     = wb_cyc_i & wb_stb_i & ~ack_ff;
wire wr_lane = wb_we_i & wb_sel_i[0];

always @* begin
    nxt_hit   = 1'b1;
    nxt_rdata = 8'h00;
    case (wb_adr_i)
        `CVR_ADR_CMP_CFG: begin
            nxt_rdata = cmp_cfg_ff;
            nxt_rdata[`CVR_BIT_RESULT] = comparator_result;
        end
        `CVR_ADR_GATE_SYNC:
            nxt_rdata = comparator_gate_sync_config_ff
                        & `CVR_MSK_GATE_SYNC;
        `CVR_ADR_VREF_CTRL:
            nxt_rdata = voltage_reference_control_ff;
        `CVR_ADR_STATUS:
            nxt_rdata = {4'h0, ladder_power, timer_count_en,
                         timer_gate, sync_out_ff};
        default:
            nxt_hit = 1'b0;
    endcase
end

always @(posedge ref_clk) begin
    if (reset) begin
        cmp_cfg_ff                     <= `CVR_RST_CMP_CFG;
        comparator_gate_sync_config_ff <= `CVR_RST_GATE_SYNC;
        voltage_reference_control_ff   <= `CVR_RST_VREF_CTRL;
        ack_ff                         <= 1'b0;
        wb_dat_o                       <= {DATA_W{1'b0}};
    end else begin
        ack_ff <= req;
        if (req) begin
            wb_dat_o <= {{(DATA_W-8){1'b0}}, nxt_rdata};
        end
        if (req & wr_lane & nxt_hit) begin
            case (wb_adr_i)
                `CVR_ADR_CMP_CFG:
                    cmp_cfg_ff <= wb_dat_i[7:0] & `CVR_MSK_CMP_CFG;
                `CVR_ADR_GATE_SYNC:
                    comparator_gate_sync_config_ff <=
                        wb_dat_i[7:0] & `CVR_MSK_GATE_SYNC;
                `CVR_ADR_VREF_CTRL:
                    voltage_reference_control_ff <=
                        wb_dat_i[7:0] & `CVR_MSK_VREF_CTRL;
                default: ;
            endcase
        end
    end
end

// unmapped addresses end the cycle with err instead of ack
reg err_ff;
always @(posedge ref_clk) begin
    if (reset) begin
        err_ff <= 1'b0;
    end else begin
        err_ff <= req & ~nxt_hit;
    end
end
assign wb_ack_o = ack_ff & ~err_ff;
assign wb_err_o = ack_ff & err_ff;

// ---------------------------------------------------------------------
// comparator controls
// ---------------------------------------------------------------------
wire output_invert      = cmp_cfg_ff[`CVR_BIT_INVERT];
wire gate_source_select =
    comparator_gate_sync_config_ff[`CVR_BIT_GATE_SEL];
wire output_sync_enable =
    comparator_gate_sync_config_ff[`CVR_BIT_SYNC_EN];

assign comparator_mode_field =
    cmp_cfg_ff[`CVR_MODE_HI:`CVR_MODE_LO];
assign input_switch = cmp_cfg_ff[`CVR_BIT_SWITCH];
// high selects the positive pin onto the inverting input
assign switch_active = input_switch &
    ((comparator_mode_field == `CVR_MODE_SW_A) |
     (comparator_mode_field == `CVR_MODE_SW_B));

wire cmp_conditioned = comparator_raw ^ output_invert;

// ---------------------------------------------------------------------
// sync latch and timer gate
// ---------------------------------------------------------------------
// timer clock arrives already prescaled, so the latch sees that rate
wire tclk_fall = tclk_prev_ff & ~timer_clk_prescaled;
wire tclk_rise = ~tclk_prev_ff & timer_clk_prescaled;

// edge history follows the pin through reset, so no false edge
// shows up on the first cycle after it
always @(posedge ref_clk) begin
    tclk_prev_ff <= timer_clk_prescaled;
    if (reset) begin
        sync_out_ff <= 1'b0;
    end else if (tclk_fall) begin
        sync_out_ff <= cmp_conditioned;
    end
end

always @* begin
    if (output_sync_enable) begin
        comparator_result = sync_out_ff;
    end else begin
        comparator_result = cmp_conditioned;
    end
    if (gate_source_select) begin
        timer_gate = external_gate_pin;
    end else begin
        timer_gate = comparator_result;
    end
    // count pulse on rising edge, away from the latching fall
    timer_count_en = tclk_rise & timer_on &
        (~timer_gate_enable | timer_gate);
end

// ---------------------------------------------------------------------
// reference ladder
// ---------------------------------------------------------------------
assign reference_enable =
    voltage_reference_control_ff[`CVR_BIT_REF_EN];
assign reference_range_select =
    voltage_reference_control_ff[`CVR_BIT_REF_RANGE];
assign reference_level =
    voltage_reference_control_ff[`CVR_LEVEL_HI:`CVR_LEVEL_LO];

// output code is the reference in units of supply over 96
always @(posedge ref_clk) begin
    if (reset) begin
        ladder_power     <= 1'b0;
        reference_output <= 8'h00;
    end else begin
        ladder_power <= reference_enable;
        if (!reference_enable) begin
            reference_output <= 8'h00;
        end else if (reference_range_select) begin
            reference_output <= {4'h0, reference_level}
                                * `CVR_LOW_STEP;
        end else begin
            reference_output <= `CVR_HIGH_BASE
                + {4'h0, reference_level} * `CVR_HIGH_STEP;
        end
    end
end

endmodule // cvr_control
`default_nettype wire

// ---- cvr_far_model.sv ----
// far side: prescaled timer clock and comparator front end
// assumes ref_clk from the bench; timer clock is ref_clk over four
`timescale 1ns/100ps
`default_nettype none
module cvr_far_model (
    input  wire logic       ref_clk,
    input  wire logic [7:0] analog_level,
    input  wire logic [7:0] reference_output,
    output wire logic       timer_clk_prescaled,
    output wire logic       comparator_raw
);
    logic [1:0] div_ff = 2'h0;
    always @(posedge ref_clk) begin
        div_ff <= div_ff + 2'h1;
    end
    assign timer_clk_prescaled = div_ff[1];
    assign comparator_raw = analog_level > reference_output;
endmodule // cvr_far_model
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the control block
// assumes the far-side model and the bound checker
`timescale 1ns/100ps
`default_nettype none
`include "cvr_consts.vh"
module tb_top;
    logic ref_clk = 0, reset = 1, cyc = 0, we = 0, on = 0, gen = 0, pin = 0;
    logic [3:0] adr = 0, sel = 0, rlv;
    logic [31:0] wd = 0, rd, dat_o;
    logic [7:0] lvl = 0, ref_o, m [3];
    logic [2:0] mode;
    logic ack, err, es, res, tclk, raw, gate, cen, lad, e, sw, swa, ren, rrs;
    int fails = 0, check_count = 0, cyc_n = 0, n, i;
    always #4 ref_clk = ~ref_clk;
    cvr_far_model far (.ref_clk, .analog_level(lvl), .reference_output(ref_o),
        .timer_clk_prescaled(tclk), .comparator_raw(raw));
    cvr_control dut (.ref_clk, .reset, .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
        .comparator_raw(raw), .comparator_result(res),
        .comparator_mode_field(mode), .input_switch(sw), .switch_active(swa),
        .timer_clk_prescaled(tclk), .timer_on(on), .timer_gate_enable(gen),
        .external_gate_pin(pin), .timer_gate(gate), .timer_count_en(cen),
        .reference_enable(ren), .reference_range_select(rrs),
        .reference_level(rlv), .ladder_power(lad), .reference_output(ref_o));
    task automatic chk(input string nm, input logic [31:0] s, x);
        check_count++;
        if (s !== x) begin
            fails++;
            $display("CHECK FAILED %s exp %h seen %h", nm, x, s);
        end
    endtask
    task automatic bus(input logic w, input int r, input logic [7:0] d,
        input logic [3:0] s);
        cyc <= 1; we <= w; adr <= 4'(r); wd <= {24'h0, d}; sel <= s;
        do @(posedge ref_clk); while (ack !== 1'b1 && err !== 1'b1);
        rd = dat_o;
        es = err;
        cyc <= 0; we <= 0;
        @(posedge ref_clk);
        if (w && s[0] && r < 12) m[r/4] = d & (r == 0 ? `CVR_MSK_CMP_CFG :
            r == 4 ? `CVR_MSK_GATE_SYNC : `CVR_MSK_VREF_CTRL);
    endtask
    function automatic logic [7:0] vexp();
        vexp = !m[2][7] ? 8'h00 : m[2][5] ? 8'h04 * m[2][3:0]
            : 8'h18 + 8'h03 * m[2][3:0];
    endfunction
    function automatic logic swexp(input logic [7:0] c);
        swexp = c[3] && (c[2:0] == 3'h6 || c[2:0] == 3'h5);
    endfunction
    task automatic print_verdict;
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    always @(posedge ref_clk) if (++cyc_n == 5000) begin
        fails++;
        print_verdict;
    end
    initial begin
        n = $urandom(32'hF0B0);
        m = '{8'h00, 8'h02, 8'h00};
        repeat (2) @(posedge ref_clk);
        reset <= 0;
        for (i = 0; i < 3; i++) begin
            bus(0, i * 4, 0, 0);
            chk("reset_value", rd, m[i]);
        end
        bus(0, 1, 0, 0);
        chk("unmapped", {rd[30:0], es}, 1);
        $display("done reset");
        for (i = 0; i < 40; i++) begin
            n = $urandom % 4;
            bus(1, n * 4, 8'($urandom), 4'($urandom));
            lvl <= 8'($urandom % 97);
            pin <= 1'($urandom);
            bus(0, n * 4, 0, 0);
            e = (lvl > vexp()) ^ m[0][4];
            if (n < 3) chk("readback", rd & ~32'h40, m[n]);
            else chk("status", rd & ~32'h3, 32'(m[2][7]) << 3);
            if (n == 0 && !m[1][0]) chk("result_bit", rd[6], e);
            if (n == 3 && !m[1][0])
                chk("status_gate", rd[1], m[1][1] ? pin : e);
            chk("ref_out", {lad, ref_o}, {m[2][7], vexp()});
            chk("refs", {ren, 1'b0, rrs, 1'b0, rlv}, m[2]);
            chk("ctl", {sw, mode}, m[0][3:0]);
            chk("swa", swa, swexp(m[0]));
            if (!m[1][0])
                chk("gate", {gate, res}, {m[1][1] ? pin : e, e});
        end
        bus(1, 8, 8'h20, 1);
        chk("clamp", {lad, ref_o}, 0);
        for (i = 0; i < 4; i++) begin
            bus(1, 0, 8'h0C | 8'(i + 4), 1);
            chk("switch", swa, i == 1 || i == 2);
        end
        $display("done registers");
        bus(1, 0, 8'h00, 1);
        bus(1, 8, 8'h80, 1);
        bus(1, 4, 8'h01, 1);
        lvl <= 8'h00;
        repeat (8) @(posedge ref_clk);
        do @(posedge ref_clk); while (tclk !== 1'b1);
        lvl <= 8'h32;
        @(posedge ref_clk);
        chk("sync_hold", {gate, res}, 0);
        repeat (4) @(posedge ref_clk);
        chk("sync_take", {gate, res}, 3);
        $display("done sync");
        bus(1, 4, 8'h02, 1);
        for (i = 0; i < 16; i++) begin
            if (i == 8) bus(1, 4, 8'h00, 1);
            {on, gen, pin} <= 3'(i);
            lvl <= i[0] ? 8'h60 : 8'h00;
            repeat (4) @(posedge ref_clk);
            n = 0;
            repeat (64) @(posedge ref_clk) n += cen;
            chk("count", n, (i[2] && (!i[1] || i[0])) ? 16 : 0);
        end
        $display("done timer");
        print_verdict;
    end
endmodule // tb_top
`default_nettype wire
